// File: ipr_pkg.sv
// Package: register map and field layout for the line urgency registers
package ipr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] IRQ_LINES_0_TO_3_PRIORITY_OFS   = 12'h400;
  localparam logic [11:0] IRQ_LINES_4_TO_7_PRIORITY_OFS   = 12'h404;
  localparam logic [11:0] IRQ_LINES_8_TO_11_PRIORITY_OFS  = 12'h408;
  localparam logic [11:0] IRQ_LINES_12_TO_15_PRIORITY_OFS = 12'h40c;
  localparam logic [11:0] PRIO_BASE_OFS                   = 12'h400;
  localparam int          NUM_REGS                        = 4;
  localparam int          LINES_PER_REG                   = 4;
  localparam int          NUM_LINES                       = 16;
  localparam logic [31:0] PRIO_RESET_VAL                  = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int          FIELD_LSB_IN_LANE               = 6;
  localparam int          LANE_WIDTH                      = 8;
  localparam int          FIELD_WIDTH                     = 2;
  localparam logic [1:0]  URGENCY_HIGHEST                 = 2'h0;
  localparam logic [1:0]  URGENCY_LOWEST                  = 2'h3;
  localparam logic [31:0] PRIO_FIELD_MASK                 = 32'hc0c0_c0c0;
  localparam logic [5:0]  VECTOR_OFFSET                   = 6'h10;
  localparam logic [31:0] UNMAPPED_RDATA                  = 32'h0000_0000;
endpackage

// File: ipr_regs.sv
// Design: APB register block for urgency of interrupt lines 0 to 15
//
// Overview of operation
// [R1] Four 2-bit fields per register, top of lanes
// [R2] Zero is most urgent, three least urgent
// [R3] Reset clears every register to zero
// [R4] Registers at 0x400 to 0x40c, word stride
// [R5] Every field writable and reads back
// [R6] Line n maps to vector n plus sixteen
// [R7] Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
module ipr_regs
  import ipr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic      [31:0] line_urgency,
  output logic      [95:0] line_vector
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte offset of register k
  function automatic logic [11:0] reg_ofs(input int k);
    reg_ofs = PRIO_BASE_OFS + 12'(4 * k);
  endfunction

  // Urgency field held in one byte lane of a register word
  function automatic logic [1:0] field_of(input logic [31:0] word,
                                          input int          lane);
    field_of = word[LANE_WIDTH*lane+FIELD_LSB_IN_LANE +: FIELD_WIDTH];
  endfunction

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [31:0] prio_q [NUM_REGS];
  logic [31:0] prio_d [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic        any_hit;
  logic        wr_acc;
  logic [31:0] lane_mask;
  logic [31:0] rd_mux;
  logic        rd_setup;

  assign any_hit   = |hit;
  assign rd_setup  = psel && !penable && !pwrite;
  assign wr_acc    = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !any_hit;
  assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}} & PRIO_FIELD_MASK; // R7

  generate
    for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
      // Word decode in line order
      assign hit[k] = (paddr == reg_ofs(k)); // R4

      property p_reg_reset;
        @(posedge ref_clk) srst |=> (prio_q[k] == PRIO_RESET_VAL);
      endproperty
      a_reg_reset: assert property (p_reg_reset) // R3
        else $error("Register not cleared by reset");

      assign prio_d[k] = (wr_acc && hit[k]) ?
        ((prio_q[k] & ~lane_mask) | (pwdata & lane_mask)) : prio_q[k]; // R5
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          prio_q[k] <= PRIO_RESET_VAL; // R3
        end else begin
          prio_q[k] <= prio_d[k];
        end
      end
      for (genvar j = 0; j < LINES_PER_REG; j++) begin : g_line
        // Field for line 4k+j at bits [8j+7:8j+6]
        assign line_urgency[2*(4*k+j) +: 2] =
          field_of(prio_q[k], j); // R1 R2
        assign line_vector[6*(4*k+j) +: 6] =
          6'(4*k+j) + VECTOR_OFFSET; // R6

        property p_field_write;
          @(posedge ref_clk) disable iff (srst)
            (wr_acc && hit[k] && pstrb[j]) |=>
              (line_urgency[2*(4*k+j) +: 2] ==
                $past(pwdata[LANE_WIDTH*j+FIELD_LSB_IN_LANE +: 2]));
        endproperty
        a_field_write: assert property (p_field_write) // R1
          else $error("Strobed field not written");

        property p_strobe_keep;
          @(posedge ref_clk) disable iff (srst)
            (wr_acc && hit[k] && !pstrb[j]) |=>
              $stable(line_urgency[2*(4*k+j) +: 2]);
        endproperty
        a_strobe_keep: assert property (p_strobe_keep) // R5
          else $error("Unstrobed field changed");

        property p_lane_readback;
          @(posedge ref_clk) disable iff (srst)
            (rd_setup && hit[k]) |=>
              (prdata[LANE_WIDTH*j+FIELD_LSB_IN_LANE +: 2] ==
                line_urgency[2*(4*k+j) +: 2]);
        endproperty
        a_lane_readback: assert property (p_lane_readback) // R5
          else $error("Read lane differs from stored field");
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = UNMAPPED_RDATA;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (hit[k]) begin
        rd_mux = prio_q[k] & PRIO_FIELD_MASK; // R7
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= UNMAPPED_RDATA;
    end else if (rd_setup) begin
      prdata <= rd_mux; // R5
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_reserved_zero;
    @(posedge ref_clk) disable iff (srst)
      ((prio_q[0] | prio_q[1] | prio_q[2] | prio_q[3]) & ~PRIO_FIELD_MASK)
        == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R7
    else $error("Reserved bit set");

  property p_reset_clear;
    @(posedge ref_clk) srst |=> (line_urgency == 32'h0000_0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // R3
    else $error("Urgency not cleared by reset");

  property p_write_lands;
    @(posedge ref_clk) disable iff (srst)
      (wr_acc && hit[0] && pstrb[0]) |=>
        (line_urgency[1:0] == $past(pwdata[7:6]));
  endproperty
  a_write_lands: assert property (p_write_lands) // R1
    else $error("Line 0 field not written");

  property p_readback;
    @(posedge ref_clk) disable iff (srst)
      (psel && !penable && !pwrite && hit[3]) |=>
        (prdata[31:30] == line_urgency[31:30]);
  endproperty
  a_readback: assert property (p_readback) // R5
    else $error("Read does not return stored value");

  property p_hold;
    @(posedge ref_clk) disable iff (srst)
      (!wr_acc && !srst) |=> $stable(line_urgency);
  endproperty
  a_hold: assert property (p_hold) // R5
    else $error("Urgency changed without write");

  property p_decode;
    @(posedge ref_clk) disable iff (srst)
      (paddr == 12'h40c) |-> hit[3] && !pslverr;
  endproperty
  a_decode: assert property (p_decode) // R4
    else $error("Top register not decoded");

  property p_vector;
    @(posedge ref_clk) line_vector[95:90] == 6'h1f;
  endproperty
  a_vector: assert property (p_vector) // R6
    else $error("Vector of line 15 wrong");

  property p_unmapped;
    @(posedge ref_clk) disable iff (srst)
      (psel && !penable && !pwrite && !any_hit) |=> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) // R4
    else $error("Unmapped read not zero");

  property p_unmapped_write;
    @(posedge ref_clk) disable iff (srst)
      (wr_acc && !any_hit) |=> $stable(line_urgency);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) // R4
    else $error("Unmapped write changed a field");

  property p_read_mask;
    @(posedge ref_clk) disable iff (srst)
      (rd_setup && any_hit) |=> ((prdata & ~PRIO_FIELD_MASK) == 32'h0);
  endproperty
  a_read_mask: assert property (p_read_mask) // R7
    else $error("Reserved bits read nonzero");

  property p_reset_rdata;
    @(posedge ref_clk) srst |=> (prdata == 32'h0000_0000);
  endproperty
  a_reset_rdata: assert property (p_reset_rdata) // R3
    else $error("Read data not cleared by reset");

  property p_vector_base;
    @(posedge ref_clk) line_vector[5:0] == VECTOR_OFFSET;
  endproperty
  a_vector_base: assert property (p_vector_base) // R6
    else $error("Vector of line 0 wrong");

  c_write: cover property (@(posedge ref_clk) wr_acc && hit[2]);
  c_read: cover property (@(posedge ref_clk) psel && !pwrite && hit[1]);
  c_lowest: cover property (@(posedge ref_clk)
    line_urgency[31:30] == URGENCY_LOWEST);
  c_unmapped: cover property (@(posedge ref_clk) pslverr);
  c_strobe: cover property (@(posedge ref_clk) wr_acc && pstrb != 4'hf);
endmodule
`default_nettype wire

// File: ipr_far.sv
// Far-side model: sel picks one line's urgency and vector
`timescale 1ns/1ps
`default_nettype none
module ipr_far (
  input  wire logic [31:0] line_urgency,
  input  wire logic [95:0] line_vector,
  input  wire logic [3:0]  sel,
  output logic      [1:0]  urg,
  output logic      [5:0]  vec
);
  assign urg = line_urgency[{sel, 1'b0} +: 2];
  assign vec = line_vector[int'(sel) * 6 +: 6];
endmodule
`default_nettype wire

// File: irq_priority_regs_0_15_bench.sv
// Bench: APB scenarios for the line urgency registers
`timescale 1ns/1ps
`default_nettype none
module irq_priority_regs_0_15_bench;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, line_urgency, rd, lu, e;
  logic [3:0]  pstrb, sel;
  logic [95:0] line_vector;
  logic [1:0]  urg;
  logic [5:0]  vec;
  int          fails = 0, n_checks = 0;
  ipr_regs dut_u (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .line_urgency(line_urgency), .line_vector(line_vector));
  ipr_far far_u (.line_urgency(line_urgency),
    .line_vector(line_vector), .sel(sel), .urg(urg), .vec(vec));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // ---------------------------------------------------------------
  // APB transfer: setup, then access until pready
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int i;
    i = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      fails++;
      results();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, 12'h400 + 12'(4 * k), 32'h0, 4'h0);
      chk(rd, 32'h0);
    end
    chk(line_urgency, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_rw();
    lu = 32'h0;
    for (int k = 0; k < 4; k++) begin
      e = 32'h0;
      for (int j = 0; j < 4; j++) begin
        e[8 * j + 6 +: 2] = 2'((j + k) % 4);
        lu[8 * k + 2 * j +: 2] = 2'((j + k) % 4);
      end
      xfer(1'b1, 12'h400 + 12'(4 * k), e | 32'h3f3f_3f3f, 4'hf);
      xfer(1'b0, 12'h400 + 12'(4 * k), 32'h0, 4'h0);
      chk(rd, e);
      chk({31'h0, se}, 32'h0);
    end
    chk(line_urgency, lu);
    for (int n = 0; n < 16; n++) begin
      sel <= 4'(n);
      @(posedge ref_clk);
      chk({30'h0, urg}, {30'h0, lu[2 * n +: 2]});
      chk({26'h0, vec}, 32'(n + 16));
    end
    $display("read write done");
  endtask
  task automatic t_edge();
    xfer(1'b1, 12'h400, 32'h0, 4'h8);
    xfer(1'b1, 12'h410, 32'hffff_ffff, 4'hf);
    chk({31'h0, se}, 32'h1);
    xfer(1'b0, 12'h410, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk({31'h0, se}, 32'h1);
    xfer(1'b0, 12'h400, 32'h0, 4'h0);
    chk(rd, 32'h0080_4000);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    xfer(1'b0, 12'h404, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(line_urgency, 32'h0);
    $display("strobe unmapped reset done");
  endtask
  initial begin
    {srst, psel, penable, pwrite} <= 4'h8;
    {paddr, pwdata, pstrb, sel} <= '0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_edge();
    results();
  end
endmodule
`default_nettype wire
